// ---- design/hppc_cfg.svh ----
// Constants for the host port pin control block.
`ifndef HPPC_CFG_SVH
`define HPPC_CFG_SVH

`define HPPC_SYNC_STAGES  2
`define HPPC_PINS_W       10
`define HPPC_B_SEL        0
`define HPPC_B_DSA        1
`define HPPC_B_DSB        2
`define HPPC_B_AS         3
`define HPPC_B_DIR        4
`define HPPC_B_HALF       5
`define HPPC_B_RS0        6
`define HPPC_B_RS1        7
`define HPPC_B_OFF        8
`define HPPC_B_STRAP      9
`define HPPC_PIN_RST      10'h1ff
`define HPPC_STRAP_SETTLE 2'h2
`define HPPC_FLD_W        4

`endif

// ---- design/hppc_pkg.sv ----
// Types shared by the host port pin control modules.
package hppc_pkg;
  typedef enum logic [1:0] {
    HPPC_IDLE,
    HPPC_BUSY,
    HPPC_HOLD
  } hppc_state_t;
  typedef logic [1:0] hppc_rsel_t;
  typedef logic [3:0] hppc_fld_t;
endpackage

// ---- design/hppc_if.sv ----
// Bundle between the synchroniser, the strap sampler and the control logic.
`timescale 1ns/1ns
`include "hppc_cfg.svh"
interface hppc_if;
  logic [`HPPC_PINS_W-1:0] pins_s;
  logic                    port_en;
  logic                    pullup_en;
  modport sync_mp  (output pins_s);
  modport strap_mp (input pins_s, output port_en, output pullup_en);
  modport ctl_mp   (input pins_s, input port_en, input pullup_en);
endinterface

// ---- design/hppc_sync.sv ----
// Two-stage synchroniser for the host port input pins.
`timescale 1ns/1ns
`include "hppc_cfg.svh"
module hppc_sync #(
  parameter int                W   = `HPPC_PINS_W,
  parameter logic [W-1:0]      RST = `HPPC_PIN_RST
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] async_i,
  hppc_if.sync_mp           sio
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta_q <= RST;
      sync_q <= RST;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sio.pins_s = sync_q;
endmodule

// ---- design/hppc_strap.sv ----
// Samples the port enable strap once after each device reset.
`timescale 1ns/1ns
`include "hppc_cfg.svh"
module hppc_strap (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  hppc_if.strap_mp  sio
);
  import hppc_pkg::*;

  logic       armed_q;
  logic       armed_d;
  logic [1:0] settle_q;
  logic [1:0] settle_d;
  logic       en_q;
  logic       en_d;

  // Sampling waits for the synchroniser to flush its reset value.
  always_comb begin
    armed_d  = armed_q;
    settle_d = settle_q;
    en_d     = en_q;
    if (armed_q) begin
      if (settle_q == 2'h0) begin
        en_d    = sio.pins_s[`HPPC_B_STRAP];
        armed_d = 1'b0;
      end else begin
        settle_d = settle_q - 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      armed_q  <= 1'b1;
      settle_q <= `HPPC_STRAP_SETTLE;
      en_q     <= 1'b0;
    end else begin
      armed_q  <= armed_d;
      settle_q <= settle_d;
      en_q     <= en_d;
    end
  end

  assign sio.port_en   = en_q;
  assign sio.pullup_en = !en_q;

  AST_STRAP_SAMPLE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    armed_q && settle_q == 2'h0 |=> en_q == $past(sio.pins_s[`HPPC_B_STRAP]))
    else $error("Port enable does not follow the sampled strap.");

  AST_STRAP_IGNORE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !armed_q |=> $stable(en_q) && !armed_q)
    else $error("Port enable changed after the strap was sampled.");

  AST_STRAP_LOW_OFF: assert property (@(posedge clk_i) disable iff (!rstn_i)
    armed_q |-> !en_q)
    else $error("Port enabled before the strap was sampled.");
endmodule

// ---- design/hppc_top.sv ----
// Pin control logic of the eight-bit parallel host port.
`timescale 1ns/1ns
`include "hppc_cfg.svh"
module hppc_top (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              port_select_n_i,
  input  wire logic              data_strobe_a_n_i,
  input  wire logic              data_strobe_b_n_i,
  input  wire logic              address_strobe_n_i,
  input  wire logic              transfer_direction_i,
  input  wire logic              byte_half_select_i,
  input  wire logic              register_select_0_i,
  input  wire logic              register_select_1_i,
  input  wire logic              port_enable_strap_i,
  input  wire logic              output_off_n_i,
  input  wire logic              timer_one_output_i,
  input  wire logic              timer_on_int_pin_i,
  input  wire logic              host_int_req_i,
  input  wire logic              access_done_i,
  output logic                   host_ready_o,
  output logic                   host_ready_oe_n_o,
  output logic                   host_interrupt_n_o,
  output logic                   host_interrupt_oe_n_o,
  output logic                   pullup_en_o,
  output logic                   port_enabled_o,
  output logic                   access_start_o,
  output logic                   access_write_o,
  output logic                   access_second_byte_o,
  output hppc_pkg::hppc_rsel_t   access_reg_o
);
  import hppc_pkg::*;

  hppc_if sio ();

  logic [`HPPC_PINS_W-1:0] pins;

  assign pins = {port_enable_strap_i,
                 output_off_n_i,
                 register_select_1_i,
                 register_select_0_i,
                 byte_half_select_i,
                 transfer_direction_i,
                 address_strobe_n_i,
                 data_strobe_b_n_i,
                 data_strobe_a_n_i,
                 port_select_n_i};

  hppc_sync #(
    .W   (`HPPC_PINS_W),
    .RST (`HPPC_PIN_RST)
  ) u_sync (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .async_i (pins),
    .sio     (sio.sync_mp)
  );

  hppc_strap u_strap (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .sio    (sio.strap_mp)
  );

  // Synchronised pin levels.
  logic       sel_n_s;
  logic       dsa_n_s;
  logic       dsb_n_s;
  logic       as_n_s;
  logic       off_n_s;
  hppc_fld_t  live_fld;

  assign sel_n_s  = sio.pins_s[`HPPC_B_SEL];
  assign dsa_n_s  = sio.pins_s[`HPPC_B_DSA];
  assign dsb_n_s  = sio.pins_s[`HPPC_B_DSB];
  assign as_n_s   = sio.pins_s[`HPPC_B_AS];
  assign off_n_s  = sio.pins_s[`HPPC_B_OFF];
  assign live_fld = {sio.pins_s[`HPPC_B_RS1],
                     sio.pins_s[`HPPC_B_RS0],
                     sio.pins_s[`HPPC_B_HALF],
                     sio.pins_s[`HPPC_B_DIR]};

  // While the address strobe is low the latched fields rule; otherwise the pins pass.
  function automatic hppc_fld_t pick_fld(input logic as_n,
                                         input hppc_fld_t live,
                                         input hppc_fld_t held);
    pick_fld = as_n ? live : held;
  endfunction

  // Only one data strobe low with select low forms a strobe; both low is not one.
  logic strobe_act;
  assign strobe_act = sio.port_en && !sel_n_s && (dsa_n_s ^ dsb_n_s);

  // Edge history and address latch.
  logic      strobe_prev_q;
  logic      strobe_prev_d;
  logic      as_prev_q;
  logic      as_prev_d;
  hppc_fld_t held_fld_q;
  hppc_fld_t held_fld_d;
  hppc_fld_t cur_fld;
  logic      start;

  assign cur_fld = pick_fld(as_n_s, live_fld, held_fld_q);
  assign start   = strobe_act && !strobe_prev_q;

  always_comb begin
    strobe_prev_d = strobe_act;
    as_prev_d     = as_n_s;
    held_fld_d    = held_fld_q;
    if (!as_n_s && as_prev_q && sio.port_en) begin
      held_fld_d = live_fld;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      strobe_prev_q <= 1'b0;
      as_prev_q     <= 1'b1;
      held_fld_q    <= 4'h0;
    end else begin
      strobe_prev_q <= strobe_prev_d;
      as_prev_q     <= as_prev_d;
      held_fld_q    <= held_fld_d;
    end
  end

  // Transfer sequencer.
  hppc_state_t state_q;
  hppc_state_t state_d;
  logic        ready_q;
  logic        ready_d;
  logic        start_q;
  logic        start_d;
  logic        write_q;
  logic        write_d;
  logic        half_q;
  logic        half_d;
  hppc_rsel_t  reg_q;
  hppc_rsel_t  reg_d;

  always_comb begin
    state_d = state_q;
    start_d = 1'b0;
    write_d = write_q;
    half_d  = half_q;
    reg_d   = reg_q;
    unique case (state_q)
      HPPC_IDLE: begin
        if (start) begin
          state_d = HPPC_BUSY;
          start_d = 1'b1;
          write_d = !cur_fld[0];
          half_d  = cur_fld[1];
          reg_d   = cur_fld[3:2];
        end
      end
      HPPC_BUSY: begin
        if (access_done_i) begin
          state_d = HPPC_HOLD;
        end
      end
      HPPC_HOLD: begin
        // The strobe must end before ready returns, so one strobe is one transfer.
        if (!strobe_act) begin
          state_d = HPPC_IDLE;
        end
      end
    endcase
    ready_d = (state_d == HPPC_IDLE);
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_q <= HPPC_IDLE;
      ready_q <= 1'b1;
      start_q <= 1'b0;
      write_q <= 1'b0;
      half_q  <= 1'b0;
      reg_q   <= 2'h0;
    end else begin
      state_q <= state_d;
      ready_q <= ready_d;
      start_q <= start_d;
      write_q <= write_d;
      half_q  <= half_d;
      reg_q   <= reg_d;
    end
  end

  // Interrupt pin source.
  logic host_interrupt_n_q;
  logic host_interrupt_n_d;

  always_comb begin
    if (sio.port_en) begin
      host_interrupt_n_d = !host_int_req_i;
    end else if (timer_on_int_pin_i) begin
      host_interrupt_n_d = timer_one_output_i;
    end else begin
      host_interrupt_n_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      host_interrupt_n_q <= 1'b1;
    end else begin
      host_interrupt_n_q <= host_interrupt_n_d;
    end
  end

  assign host_ready_o          = ready_q;
  assign host_ready_oe_n_o     = !off_n_s;
  assign host_interrupt_n_o    = host_interrupt_n_q;
  assign host_interrupt_oe_n_o = !off_n_s;
  assign pullup_en_o           = sio.pullup_en;
  assign port_enabled_o        = sio.port_en;
  assign access_start_o        = start_q;
  assign access_write_o        = write_q;
  assign access_second_byte_o  = half_q;
  assign access_reg_o          = reg_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence seq_taken;
    state_q == HPPC_IDLE && start;
  endsequence

  sequence seq_released;
    state_q == HPPC_HOLD && !strobe_act;
  endsequence

  AST_START_PULSE: assert property (seq_taken |=> access_start_o ##1 !access_start_o)
    else $error("Strobe start did not give one access pulse.");

  AST_DIRECTION: assert property (seq_taken |=> access_write_o == !$past(cur_fld[0]))
    else $error("Access direction does not follow the direction input.");

  AST_BYTE_HALF: assert property (seq_taken |=> access_second_byte_o == $past(cur_fld[1]))
    else $error("Byte half does not follow the byte half input.");

  AST_READY_LOW: assert property (seq_taken |=> !host_ready_o [*2])
    else $error("Ready did not drop for a taken transfer.");

  AST_READY_BACK: assert property (seq_released |=> host_ready_o)
    else $error("Ready did not return after strobe release.");

  AST_OFF_FLOAT: assert property (!output_off_n_i [*3] |-> host_ready_oe_n_o
                                  && host_interrupt_oe_n_o)
    else $error("Outputs still driven while output off is low.");

  AST_HOST_INTERRUPT_N_RESET: assert property (@(posedge clk_i) disable iff (1'b0)
    !rstn_i |=> host_interrupt_n_o)
    else $error("Interrupt pin not high during reset.");

  AST_TIMER_ROUTE: assert property (!port_enabled_o && timer_on_int_pin_i
                                    |=> host_interrupt_n_o == $past(timer_one_output_i))
    else $error("Timer output not routed to the interrupt pin.");

  AST_SELECT_SYNC: assert property (access_start_o |-> !$past(port_select_n_i, 3))
    else $error("Access started without a synchronised select.");

  AST_PULLUP_IDLE: assert property (pullup_en_o |-> host_ready_o && !access_start_o)
    else $error("Disabled port accepted a transfer.");

  sequence seq_as_fall;
    !as_n_s && as_prev_q && sio.port_en;
  endsequence

  // A multiplexed host reuses the field pins, so the latch must catch them at the fall.
  AST_ADDR_LATCH: assert property (seq_as_fall |=> held_fld_q == $past(live_fld))
    else $error("Register selection not latched at the address strobe.");

  AST_READY_WAIT: assert property (!host_ready_o |=> !access_start_o)
    else $error("Access started while ready was low.");

  AST_OFF_DRIVE: assert property (output_off_n_i [*3] |-> !host_ready_oe_n_o
                                  && !host_interrupt_oe_n_o)
    else $error("Outputs not driven while output off is high.");

  AST_HOST_INTERRUPT_N_HOST: assert property (port_enabled_o
                                  |=> host_interrupt_n_o == !$past(host_int_req_i))
    else $error("Enabled port does not carry the host interrupt.");

  AST_STROBE_BOTH: assert property (!dsa_n_s && !dsb_n_s |-> !start)
    else $error("Both data strobes low were taken as a strobe.");
endmodule

// ---- verif/hppc_host.sv ----
// Host side model that drives the port control pins.
`timescale 1ns/1ns
module hppc_host (
  input  wire logic  clk_i,
  input  wire logic  host_ready_i,
  output logic       sel_n_o,
  output logic       dsa_n_o,
  output logic       dsb_n_o,
  output logic       as_n_o,
  output logic       dir_o,
  output logic       half_o,
  output logic [1:0] rs_o
);
  initial begin
    {sel_n_o, dsa_n_o, dsb_n_o, as_n_o} = 4'hf;
    {dir_o, half_o, rs_o} = 4'h0;
  end
  // Fields are inverted after each access so that stale values never look valid.
  // A multiplexed host keeps the address strobe low and reuses the field pins for data.
  task automatic xfer(input logic [3:0] f, input logic b, input int hold, input logic mux,
                      output logic ok);
    int n;
    @(posedge clk_i);
    {dir_o, half_o, rs_o} <= f;
    sel_n_o <= 1'b0;
    as_n_o <= 1'b0;
    @(posedge clk_i);
    if (mux) begin
      {dir_o, half_o, rs_o} <= ~f;
    end else begin
      as_n_o <= 1'b1;
    end
    if (b) begin
      dsb_n_o <= 1'b0;
    end else begin
      dsa_n_o <= 1'b0;
    end
    repeat (hold) @(posedge clk_i);
    {dsa_n_o, dsb_n_o} <= 2'h3;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (host_ready_i !== 1'b1 && n < 40);
    ok = (n < 40);
    sel_n_o <= 1'b1;
    as_n_o <= 1'b1;
    {dir_o, half_o, rs_o} <= ~f;
  endtask
endmodule

// ---- verif/tb_host_port_pin_control.sv ----
// Testbench of the host port pin control block.
`timescale 1ns/1ns
module tb_host_port_pin_control;
  import hppc_pkg::*;
  logic       clk_i, rstn_i, strap, off_n, tmr, route, int_req, done;
  logic       sel_n, dsa_n, dsb_n, as_n, dir, half, ok;
  logic [1:0] rs;
  logic [3:0] f;
  logic       rdy, rdy_oe_n, int_n, int_oe_n, pu, pen, start, wr, second;
  hppc_rsel_t reg_sel;
  int         mismatches, checks, starts;
  logic [3:0] exp_q[$];

  hppc_top dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .port_select_n_i(sel_n),
    .data_strobe_a_n_i(dsa_n), .data_strobe_b_n_i(dsb_n), .address_strobe_n_i(as_n),
    .transfer_direction_i(dir), .byte_half_select_i(half), .register_select_0_i(rs[0]),
    .register_select_1_i(rs[1]), .port_enable_strap_i(strap), .output_off_n_i(off_n),
    .timer_one_output_i(tmr), .timer_on_int_pin_i(route), .host_int_req_i(int_req),
    .access_done_i(done), .host_ready_o(rdy), .host_ready_oe_n_o(rdy_oe_n),
    .host_interrupt_n_o(int_n), .host_interrupt_oe_n_o(int_oe_n), .pullup_en_o(pu),
    .port_enabled_o(pen), .access_start_o(start), .access_write_o(wr),
    .access_second_byte_o(second), .access_reg_o(reg_sel));

  hppc_host host (
    .clk_i(clk_i), .host_ready_i(rdy), .sel_n_o(sel_n), .dsa_n_o(dsa_n), .dsb_n_o(dsb_n),
    .as_n_o(as_n), .dir_o(dir), .half_o(half), .rs_o(rs));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic check(input logic [3:0] seen, input logic [3:0] expd);
    checks++;
    if (seen !== expd) begin
      mismatches++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, expd);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Core model: finishes each access one cycle after it starts.
  always @(posedge clk_i) begin
    done <= start;
    if (start === 1'b1) begin
      starts++;
      check(4'(exp_q.size()), 4'h1);
      check({wr, second, reg_sel}, exp_q.pop_front());
      check(rdy, 1'b0);
    end
  end

  task automatic do_reset(input logic s);
    rstn_i <= 1'b0;
    strap <= s;
    repeat (8) @(posedge clk_i);
    check({rdy, int_n, pu, pen}, 4'he);
    rstn_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    check({pen, pu}, {s, ~s});
  endtask

  initial begin
    {rstn_i, strap, off_n, tmr, route, int_req} = 6'h08;
    void'($urandom(87));
    do_reset(1'b1);
    for (int i = 0; i < 12; i++) begin
      f = 4'($urandom());
      exp_q.push_back({~f[3], f[2:0]});
      host.xfer(f, i[0], 4 + i % 3, i[1], ok);
      check(ok, 1'b1);
    end
    check(4'(starts), 4'hc);
    $display("test transfers done");
    int_req <= 1'b1;
    repeat (2) @(posedge clk_i);
    check(int_n, 1'b0);
    off_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({rdy_oe_n, int_oe_n}, 2'h3);
    off_n <= 1'b1;
    int_req <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({rdy_oe_n, int_oe_n, int_n}, 3'h1);
    $display("test interrupt and output off done");
    do_reset(1'b0);
    strap <= 1'b1;
    route <= 1'b1;
    host.xfer(4'h5, 1'b0, 4, 1'b0, ok);
    check(4'(starts), 4'hc);
    check({pen, pu}, 2'h1);
    for (int i = 0; i < 2; i++) begin
      tmr <= i[0];
      repeat (2) @(posedge clk_i);
      check(int_n, i[0]);
    end
    route <= 1'b0;
    tmr <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(int_n, 1'b1);
    $display("test disabled port done");
    do_reset(1'b1);
    $display("test second reset done");
    test_done();
  end

  // Whole run is under a thousand cycles; this span leaves ample margin.
  initial begin
    #100000;
    mismatches++;
    test_done();
  end
endmodule
